// *** image_path_transfer_sequencer.sv ***
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/10ps
// How it works
// - Fax reception moves modem coded data into system receive buffer.
// - Image_coder_chip decode results are written as raster into image work region.
// - Reception re-encodes to JBIG, stores whole document before printing.
// - Stored JBIG is decoded again into page memory, or into image_coder_chip for host scan and host fax send.
// - Printing reads page memory raster (scan buffer in both copy modes) out to the print engine port.
// - Serial scan data becomes parallel words written to scan buffer.
// - Copy has normal (scan to print) and sort (via JBIG) modes.
// - Sort copy stores all documents as JBIG before printing begins.
// - Host modes: scan to host, host fax send, fax to host, print.
// - Host scan stores JBIG, decodes, encodes MH into host buffer.
// - Host-bound data goes from host buffer out through host port.
// - Host fax data lands in host buffer; decoded only if coded.
// - Host fax send: indirect stores all pages, direct goes per page.
// - Remote coding negotiation runs during buffering; encode waits for it.
// - Transmit encode uses remote-chosen format into transmit buffer.
// - Transmit encode fills transmit buffer one page at a time.
// - Transmit buffer data is fed to the modem port.
// - Fax to host re-encodes in host-chosen MH, MR or MMR.
// - Printer mode decodes host coded data into page memory, then prints.
// - Scan words are 16 bits and stored by memory transfer.
// - Memory is split into system and image work regions.
module image_path_transfer_sequencer (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Stage request to the transfer engine
    output xfer_seq_pkg::xfer_t xfer,
    output logic xfer_valid,
    input wire logic xfer_done,
    // Scan controller serial input
    input wire logic scan_sck,
    input wire logic scan_sd,
    input wire logic scan_en_n,
    // Parallel scan words toward memory
    output xfer_seq_pkg::scan_word_t scan_out
);
    import xfer_seq_pkg::*;

    typedef struct packed {
        fsm_t fsm;
        kind_t kind;
        mode_t mode;
        logic store_all;
        logic host_coded;
        fmt_t host_fmt;
        fmt_t remote_fmt;
        logic fmt_ok;
        logic last_doc;
        logic replay;
        logic stage_done;
        logic run_end;
        logic [7:0] stages;
        logic [7:0] stored;
        logic [7:0] left;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
        logic xfer_valid;
        xfer_t xfer;
        scan_word_t scan_out;
    } state_t;

    state_t s_r;
    state_t s_nxt;
    scan_word_t des_word;

    scan_deserializer u_des (
        .pclk(pclk),
        .presetn(presetn),
        .scan_sck(scan_sck),
        .scan_sd(scan_sd),
        .scan_en_n(scan_en_n),
        .word(des_word)
    );

    function automatic region_t region_of(input buf_t b);
        case (b)
            BUF_RX, BUF_TX, BUF_IMAGE: region_of = REG_SYS;
            BUF_IMAGE_CODER_CHIP, BUF_PAGE, BUF_SCAN, BUF_PC: region_of = REG_IMG;
            default: region_of = REG_EXT;
        endcase
    endfunction : region_of

    // Modes that keep every document as JBIG before output
    function automatic logic stores(input mode_t m, input logic opt);
        case (m)
            MODE_FAX_RX, MODE_PC_RX, MODE_PC_SCAN: stores = 1'b1;
            MODE_COPY, MODE_PC_TX: stores = opt;
            default: stores = 1'b0;
        endcase
    endfunction : stores

    function automatic kind_t first_kind(input mode_t m);
        case (m)
            MODE_FAX_RX, MODE_PC_RX: first_kind = K_MODEM_IN;
            MODE_COPY, MODE_PC_SCAN: first_kind = K_SCAN;
            default: first_kind = K_HOST_IN;
        endcase
    endfunction : first_kind

    function automatic logic mode_ok(input logic [2:0] m);
        mode_ok = (m <= 3'(MODE_PRINTER));
    endfunction : mode_ok

    function automatic xfer_t desc_of(input kind_t k, input mode_t m,
                                      input fmt_t hf, input fmt_t rf);
        xfer_t d;
        d = XFER_RST;
        case (k)
            K_MODEM_IN: begin
                d.src = PORT_MODEM;
                d.dst = BUF_RX;
            end
            K_RX_DEC: begin
                d.src = BUF_RX;
                d.dst = BUF_IMAGE_CODER_CHIP;
                d.op = OP_DECODE;
            end
            K_JBIG_ENC: begin
                d.src = (m == MODE_COPY || m == MODE_PC_SCAN) ?
                        BUF_SCAN : BUF_IMAGE_CODER_CHIP;
                d.dst = BUF_IMAGE;
                d.op = OP_ENCODE;
                d.fmt = FMT_JBIG;
            end
            K_JBIG_DEC: begin
                d.src = BUF_IMAGE;
                d.dst = (m == MODE_PC_SCAN || m == MODE_PC_TX) ?
                        BUF_IMAGE_CODER_CHIP : BUF_PAGE;
                d.op = OP_DECODE;
                d.fmt = FMT_JBIG;
            end
            K_PRINT: begin
                d.src = (m == MODE_COPY) ? BUF_SCAN : BUF_PAGE;
                d.dst = PORT_PRINT;
            end
            K_SCAN: begin
                d.src = PORT_SCAN;
                d.dst = BUF_SCAN;
            end
            K_MH_ENC: begin
                d.src = BUF_IMAGE_CODER_CHIP;
                d.dst = BUF_PC;
                d.op = OP_ENCODE;
                d.fmt = FMT_MH;
            end
            K_HOST_OUT: begin
                d.src = BUF_PC;
                d.dst = PORT_HOST;
            end
            K_HOST_IN: begin
                d.src = PORT_HOST;
                d.dst = BUF_PC;
            end
            K_HOST_DEC: begin
                d.src = BUF_PC;
                d.dst = BUF_IMAGE_CODER_CHIP;
                d.op = OP_DECODE;
            end
            K_TX_ENC: begin
                d.src = BUF_IMAGE_CODER_CHIP;
                d.dst = BUF_TX;
                d.op = OP_ENCODE;
                d.fmt = rf;
            end
            K_MODEM_OUT: begin
                d.src = BUF_TX;
                d.dst = PORT_MODEM;
            end
            K_HFMT_ENC: begin
                d.src = BUF_PAGE;
                d.dst = BUF_PC;
                d.op = OP_ENCODE;
                d.fmt = hf;
            end
            K_PRN_DEC: begin
                d.src = BUF_PC;
                d.dst = BUF_PAGE;
                d.op = OP_DECODE;
            end
            default: d = XFER_RST;
        endcase
        d.src_reg = region_of(d.src);
        d.dst_reg = region_of(d.dst);
        desc_of = d;
    endfunction : desc_of

    logic apb_access;
    logic apb_commit;
    logic known_addr;
    logic is_store;
    logic page_end;

    always_comb begin
        s_nxt = s_r;
        apb_access = psel && penable && !s_r.pready;
        apb_commit = psel && penable && s_r.pready && pwrite;
        known_addr = (paddr == OFF_CTRL) || (paddr == OFF_FMT) ||
                     (paddr == OFF_DOC) || (paddr == OFF_STATUS);
        is_store = stores(s_r.mode, s_r.store_all);
        page_end = 1'b0;

        // Answer one cycle into the access phase
        s_nxt.pready = apb_access;
        if (apb_access) begin
            s_nxt.pslverr = !known_addr;
            s_nxt.prdata = RDATA_RST;
            if (!pwrite) begin
                case (paddr)
                    OFF_CTRL: begin
                        s_nxt.prdata[CTRL_MODE_LSB +: 3] = s_r.mode;
                        s_nxt.prdata[CTRL_STORE_BIT] = s_r.store_all;
                        s_nxt.prdata[CTRL_CODED_BIT] = s_r.host_coded;
                        s_nxt.prdata[CTRL_HFMT_LSB +: 2] =
                            2'(s_r.host_fmt - FMT_MH);
                    end
                    OFF_FMT: begin
                        s_nxt.prdata[FMT_SEL_LSB +: 3] = s_r.remote_fmt;
                        s_nxt.prdata[FMT_VALID_BIT] = s_r.fmt_ok;
                    end
                    OFF_DOC: s_nxt.prdata[DOC_LAST_BIT] = s_r.last_doc;
                    OFF_STATUS: begin
                        s_nxt.prdata[ST_BUSY_BIT] = (s_r.fsm != ST_IDLE);
                        s_nxt.prdata[ST_DONE_BIT] = s_r.stage_done;
                        s_nxt.prdata[ST_WAITFMT_BIT] =
                            (s_r.fsm == ST_ISSUE) &&
                            (s_r.kind == K_TX_ENC) && !s_r.fmt_ok;
                        s_nxt.prdata[ST_RUNEND_BIT] = s_r.run_end;
                        s_nxt.prdata[ST_KIND_LSB +: 4] = s_r.kind;
                        s_nxt.prdata[ST_COUNT_LSB +: 8] = s_r.stages;
                        s_nxt.prdata[ST_PAGES_LSB +: 8] = s_r.stored;
                    end
                    default: s_nxt.prdata = RDATA_RST;
                endcase
            end
        end else begin
            s_nxt.pslverr = 1'b0;
        end

        // Writes land on the edge that completes the transfer
        if (apb_commit) begin
            case (paddr)
                OFF_CTRL: begin
                    if (s_r.fsm == ST_IDLE && pwdata[CTRL_START_BIT] &&
                        mode_ok(pwdata[CTRL_MODE_LSB +: 3])) begin
                        s_nxt.mode = mode_t'(pwdata[CTRL_MODE_LSB +: 3]);
                        s_nxt.store_all = pwdata[CTRL_STORE_BIT];
                        s_nxt.host_coded = pwdata[CTRL_CODED_BIT];
                        // Host picks MH, MR or MMR only
                        s_nxt.host_fmt = (pwdata[CTRL_HFMT_LSB +: 2] ==
                                          2'h3) ? FMT_MMR :
                            fmt_t'(3'(pwdata[CTRL_HFMT_LSB +: 2]) + 3'h1);
                        s_nxt.kind = first_kind(
                            mode_t'(pwdata[CTRL_MODE_LSB +: 3]));
                        s_nxt.fsm = ST_ISSUE;
                        s_nxt.fmt_ok = 1'b0;
                        s_nxt.last_doc = 1'b0;
                        s_nxt.replay = 1'b0;
                        s_nxt.run_end = 1'b0;
                        s_nxt.stages = COUNT_RST;
                        s_nxt.stored = COUNT_RST;
                        s_nxt.left = COUNT_RST;
                    end
                end
                OFF_FMT: begin
                    // Negotiation result may arrive while buffering
                    s_nxt.remote_fmt = (pwdata[FMT_SEL_LSB +: 3] >
                                        3'(FMT_JBIG)) ? FMT_JBIG :
                        fmt_t'(pwdata[FMT_SEL_LSB +: 3]);
                    s_nxt.fmt_ok = pwdata[FMT_VALID_BIT];
                end
                OFF_DOC: begin
                    if (pwdata[DOC_LAST_BIT]) begin
                        s_nxt.last_doc = 1'b1;
                    end
                end
                OFF_STATUS: begin
                    if (pwdata[ST_DONE_BIT]) begin
                        s_nxt.stage_done = 1'b0;
                    end
                    if (pwdata[ST_RUNEND_BIT]) begin
                        s_nxt.run_end = 1'b0;
                    end
                end
                default: s_nxt.pslverr = 1'b0;
            endcase
        end

        case (s_r.fsm)
            ST_IDLE: s_nxt.xfer_valid = 1'b0;
            ST_ISSUE: begin
                // Transmit coding must be known before final encode
                if (s_r.kind != K_TX_ENC || s_r.fmt_ok) begin
                    s_nxt.xfer = desc_of(s_r.kind, s_r.mode, s_r.host_fmt,
                                         s_r.remote_fmt);
                    s_nxt.xfer_valid = 1'b1;
                    s_nxt.fsm = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (xfer_done) begin
                    s_nxt.xfer_valid = 1'b0;
                    s_nxt.stage_done = 1'b1;
                    s_nxt.stages = s_r.stages + 8'h01;
                    s_nxt.fsm = ST_NEXT;
                end
            end
            ST_NEXT: begin
                s_nxt.fsm = ST_ISSUE;
                case (s_r.kind)
                    K_MODEM_IN: s_nxt.kind = K_RX_DEC;
                    K_RX_DEC: s_nxt.kind = K_JBIG_ENC;
                    K_SCAN: s_nxt.kind = is_store ? K_JBIG_ENC :
                                         K_PRINT;
                    K_HOST_IN: begin
                        if (s_r.mode == MODE_PRINTER) begin
                            s_nxt.kind = K_PRN_DEC;
                        end else if (s_r.host_coded) begin
                            s_nxt.kind = K_HOST_DEC;
                        end else begin
                            s_nxt.kind = is_store ? K_JBIG_ENC : K_TX_ENC;
                        end
                    end
                    K_HOST_DEC: s_nxt.kind = is_store ? K_JBIG_ENC :
                                             K_TX_ENC;
                    K_JBIG_ENC: begin
                        s_nxt.stored = s_r.stored + 8'h01;
                        if (s_r.last_doc) begin
                            // All documents held; replay page by page
                            s_nxt.replay = 1'b1;
                            s_nxt.left = s_r.stored + 8'h01;
                            s_nxt.kind = K_JBIG_DEC;
                        end else begin
                            s_nxt.kind = first_kind(s_r.mode);
                        end
                    end
                    K_JBIG_DEC: begin
                        case (s_r.mode)
                            MODE_PC_SCAN: s_nxt.kind = K_MH_ENC;
                            MODE_PC_TX: s_nxt.kind = K_TX_ENC;
                            MODE_PC_RX: s_nxt.kind = K_HFMT_ENC;
                            default: s_nxt.kind = K_PRINT;
                        endcase
                    end
                    K_MH_ENC, K_HFMT_ENC: s_nxt.kind = K_HOST_OUT;
                    K_TX_ENC: s_nxt.kind = K_MODEM_OUT;
                    K_PRN_DEC: s_nxt.kind = K_PRINT;
                    default: page_end = 1'b1;
                endcase
                if (page_end) begin
                    if (s_r.replay) begin
                        s_nxt.left = s_r.left - 8'h01;
                        if (s_r.left <= 8'h01) begin
                            s_nxt.fsm = ST_IDLE;
                            s_nxt.run_end = 1'b1;
                        end else begin
                            s_nxt.kind = K_JBIG_DEC;
                        end
                    end else if (s_r.last_doc) begin
                        s_nxt.fsm = ST_IDLE;
                        s_nxt.run_end = 1'b1;
                    end else begin
                        // Direct paths restart per page
                        s_nxt.kind = first_kind(s_r.mode);
                    end
                end
            end
            default: begin
                s_nxt.fsm = ST_IDLE;
                s_nxt.xfer_valid = 1'b0;
            end
        endcase

        // Scan words pass only while a scan stage is running
        s_nxt.scan_out.valid = des_word.valid && s_r.xfer_valid &&
                               (s_r.kind == K_SCAN);
        s_nxt.scan_out.data = des_word.data;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
            s_r.fsm <= ST_IDLE;
            s_r.host_fmt <= FMT_MH;
            s_r.remote_fmt <= FMT_MH;
            s_r.xfer <= XFER_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign xfer = s_r.xfer;
    assign xfer_valid = s_r.xfer_valid;
    assign scan_out = s_r.scan_out;

endmodule : image_path_transfer_sequencer

// *** scan_deserializer.sv ***
`timescale 1ns/10ps
module scan_deserializer (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Serial raster from the scan controller
    input wire logic scan_sck,
    input wire logic scan_sd,
    input wire logic scan_en_n,
    // Parallel words
    output xfer_seq_pkg::scan_word_t word
);
    import xfer_seq_pkg::*;

    typedef struct packed {
        logic sck_q;
        logic [SCAN_WORD_W-1:0] shift;
        logic [SCAN_CNT_W-1:0] cnt;
        scan_word_t word;
    } des_t;

    des_t s_r;
    des_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.sck_q = scan_sck;
        s_nxt.word.valid = 1'b0;
        if (scan_en_n) begin
            // Partial word dropped when the enable window closes
            s_nxt.cnt = '0;
        end else if (scan_sck && !s_r.sck_q) begin
            s_nxt.shift = {s_r.shift[SCAN_WORD_W-2:0], scan_sd};
            s_nxt.cnt = s_r.cnt + 1'b1;
            if (s_r.cnt == SCAN_CNT_LAST) begin
                s_nxt.word.valid = 1'b1;
                s_nxt.word.data = {s_r.shift[SCAN_WORD_W-2:0], scan_sd};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign word = s_r.word;

endmodule : scan_deserializer

// *** testbench.sv ***
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
    import xfer_seq_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, vq = 1'b0, fmt_wr = 1'b0, cd, perr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, xfer_valid, xfer_done, sck, sd, en_n;
    logic [15:0] pat = 16'h0;
    logic [7:0] stg = 8'h00, s0;
    logic [2:0] md = 3'h0, rf;
    logic [1:0] hf;
    fmt_t etx, ehf;
    xfer_t xfer;
    scan_word_t scan_out;
    int errors = 0, comparisons = 0, n;
    always #20 pclk = ~pclk;
    image_path_transfer_sequencer dut_u (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .xfer(xfer), .xfer_valid(xfer_valid), .xfer_done(xfer_done),
        .scan_sck(sck), .scan_sd(sd), .scan_en_n(en_n), .scan_out(scan_out));
    xfer_engine_model model_u (.pclk(pclk), .xfer(xfer),
        .xfer_valid(xfer_valid), .xfer_done(xfer_done), .scan_pat(pat),
        .scan_sck(sck), .scan_sd(sd), .scan_en_n(en_n));
    function automatic logic [7:0] exp_stg(input logic [2:0] m,
        input logic s, c);
        case (m)
            3'h1: return s ? 8'h04 : 8'h02;
            3'h3: return {7'h0, c} + (s ? 8'h05 : 8'h03);
            3'h4: return 8'h06;
            3'h5: return 8'h03;
            default: return 8'h05;
        endcase
    endfunction : exp_stg
    task automatic end_of_test;
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (!pready && k < 20);
        if (k >= 20) begin
            errors++;
            end_of_test();
        end
        r = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    always @(posedge pclk) begin
        vq <= xfer_valid;
        if (scan_out.valid) `CHK(scan_out.data, pat)
        if (xfer_valid && !vq) begin
            stg <= stg + 8'h01;
            if (xfer.dst == BUF_TX) begin
                `CHK(fmt_wr, 1'b1)
                `CHK(xfer.fmt, etx)
            end else if (xfer.op == OP_ENCODE && xfer.fmt != FMT_JBIG)
                `CHK(xfer.fmt, md == 3'h2 ? FMT_MH : ehf)
        end
    end
    initial begin
        repeat (60000) @(posedge pclk);
        errors++;
        end_of_test();
    end
    initial begin
        void'($urandom(32'h6c491bc3));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, OFF_STATUS, 32'h0);
        `CHK(r, 32'h0)
        apb(1'b0, 12'h010, 32'h0);
        `CHK({perr, r}, 33'h100000000)
        for (int i = 0; i < 12; i++) begin
            md = 3'(i % 6);
            pat = 16'($urandom);
            hf = 2'($urandom);
            rf = 3'($urandom_range(7, 1));
            cd = 1'($urandom);
            etx = rf > 3'h4 ? FMT_JBIG : fmt_t'(rf);
            ehf = hf == 2'h3 ? FMT_MMR : fmt_t'(hf + 2'h1);
            s0 = stg;
            fmt_wr = 1'b0;
            apb(1'b1, OFF_CTRL, {24'h0, hf, cd, 1'(i / 6), md, 1'b1});
            apb(1'b1, OFF_DOC, 32'h1);
            // Late format forces the transmit encode to wait
            if (md == 3'h3) repeat (40) @(posedge pclk);
            apb(1'b1, OFF_FMT, {28'h0, 1'b1, rf});
            fmt_wr = 1'b1;
            n = 0;
            do begin
                apb(1'b0, OFF_STATUS, 32'h0);
                n++;
            end while (!r[3] && n < 300);
            if (!r[3]) begin
                errors++;
                end_of_test();
            end
            `CHK(r[15:8], exp_stg(md, 1'(i / 6), cd))
            `CHK(stg - s0, exp_stg(md, 1'(i / 6), cd))
            `CHK(r[0], 1'b0)
            apb(1'b1, OFF_STATUS, 32'ha);
            apb(1'b0, OFF_STATUS, 32'h0);
            `CHK(r[3:1], 3'h0)
        end
        end_of_test();
    end
endmodule : testbench

// *** xfer_engine_model.sv ***
`timescale 1ns/10ps
module xfer_engine_model (
    // Clock
    input wire logic pclk,
    // Stage request
    input wire xfer_seq_pkg::xfer_t xfer,
    input wire logic xfer_valid,
    output logic xfer_done,
    // Serial scan source
    input wire logic [15:0] scan_pat,
    output logic scan_sck,
    output logic scan_sd,
    output logic scan_en_n
);
    import xfer_seq_pkg::*;
    initial begin
        {xfer_done, scan_sck, scan_sd, scan_en_n} = 4'h1;
        forever begin
            @(posedge pclk);
            if (xfer_valid && !xfer_done) begin
                if (xfer.src == PORT_SCAN) begin
                    for (int i = 15; i >= 0; i--) begin
                        scan_en_n <= 1'b0;
                        scan_sd <= scan_pat[i];
                        scan_sck <= 1'b0;
                        @(posedge pclk);
                        scan_sck <= 1'b1;
                        @(posedge pclk);
                    end
                    scan_en_n <= 1'b1;
                    scan_sck <= 1'b0;
                end
                repeat ($urandom_range(9, 3)) @(posedge pclk);
                xfer_done <= 1'b1;
                @(posedge pclk);
                xfer_done <= 1'b0;
            end else begin
                // Idle data line toggles so stale bits are never seen
                scan_sd <= ~scan_sd;
            end
        end
    end
endmodule : xfer_engine_model

// *** xfer_seq_monitor.sv ***
`timescale 1ns/10ps
module xfer_seq_monitor (
    // Bus
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Stages
    input wire xfer_seq_pkg::xfer_t xfer,
    input wire logic xfer_valid,
    input wire logic xfer_done,
    input wire xfer_seq_pkg::scan_word_t scan_out
);
    import xfer_seq_pkg::*;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_wait; psel && penable && !pready |=> pready; endproperty
    a_wait: assert property (p_wait) else $error("late answer");
    property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
    a_err: assert property (p_err) else $error("bad error");
    property p_hold; xfer_valid && !xfer_done |=> xfer_valid && $stable(xfer);
    endproperty
    a_hold: assert property (p_hold) else $error("stage moved");
    property p_drop; xfer_valid && xfer_done |=> !xfer_valid [*2]; endproperty
    a_drop: assert property (p_drop) else $error("no gap");
    property p_rx;
        xfer_valid && xfer.src == PORT_MODEM |->
            xfer.dst == BUF_RX && xfer.dst_reg == REG_SYS;
    endproperty
    a_rx: assert property (p_rx) else $error("bad rx");
    property p_prn; xfer_valid && xfer.dst == PORT_PRINT |->
        xfer.src_reg == REG_IMG;
    endproperty
    a_prn: assert property (p_prn) else $error("bad print");
    property p_dec; xfer_valid && xfer.op == OP_DECODE |->
        xfer.dst_reg == REG_IMG;
    endproperty
    a_dec: assert property (p_dec) else $error("bad decode");
    property p_modem; xfer_valid && xfer.dst == PORT_MODEM |->
        xfer.src == BUF_TX;
    endproperty
    a_modem: assert property (p_modem) else $error("bad send");
    property p_scan; scan_out.valid |=> !scan_out.valid; endproperty
    a_scan: assert property (p_scan) else $error("long word");
    c_err: cover property (pslverr);
    c_scan: cover property (scan_out.valid);
    c_stage: cover property (xfer_valid && xfer_done);
endmodule : xfer_seq_monitor
bind image_path_transfer_sequencer xfer_seq_monitor mon_u (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .xfer(xfer),
    .xfer_valid(xfer_valid), .xfer_done(xfer_done), .scan_out(scan_out));

// *** xfer_seq_pkg.sv ***
package xfer_seq_pkg;

    // Register byte offsets
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_FMT = 12'h004;
    localparam logic [11:0] OFF_DOC = 12'h008;
    localparam logic [11:0] OFF_STATUS = 12'h00c;

    // Control fields
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int CTRL_STORE_BIT = 4;
    localparam int CTRL_CODED_BIT = 5;
    localparam int CTRL_HFMT_LSB = 6;
    localparam int FMT_SEL_LSB = 0;
    localparam int FMT_VALID_BIT = 3;
    localparam int DOC_LAST_BIT = 0;

    // Status fields
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_DONE_BIT = 1;
    localparam int ST_WAITFMT_BIT = 2;
    localparam int ST_RUNEND_BIT = 3;
    localparam int ST_KIND_LSB = 4;
    localparam int ST_COUNT_LSB = 8;
    localparam int ST_PAGES_LSB = 16;

    localparam int SCAN_WORD_W = 16;
    localparam int SCAN_CNT_W = 4;
    localparam logic [SCAN_CNT_W-1:0] SCAN_CNT_LAST = 4'hf;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    typedef enum logic [2:0] {
        MODE_FAX_RX = 3'h0,
        MODE_COPY = 3'h1,
        MODE_PC_SCAN = 3'h2,
        MODE_PC_TX = 3'h3,
        MODE_PC_RX = 3'h4,
        MODE_PRINTER = 3'h5
    } mode_t;

    typedef enum logic [3:0] {
        BUF_NONE = 4'h0,
        BUF_RX = 4'h1,
        BUF_TX = 4'h2,
        BUF_IMAGE = 4'h3,
        BUF_IMAGE_CODER_CHIP = 4'h4,
        BUF_PAGE = 4'h5,
        BUF_SCAN = 4'h6,
        BUF_PC = 4'h7,
        PORT_MODEM = 4'h8,
        PORT_PRINT = 4'h9,
        PORT_SCAN = 4'ha,
        PORT_HOST = 4'hb
    } buf_t;

    typedef enum logic [1:0] {
        REG_EXT = 2'h0,
        REG_SYS = 2'h1,
        REG_IMG = 2'h2
    } region_t;

    typedef enum logic [2:0] {
        FMT_RASTER = 3'h0,
        FMT_MH = 3'h1,
        FMT_MR = 3'h2,
        FMT_MMR = 3'h3,
        FMT_JBIG = 3'h4
    } fmt_t;

    typedef enum logic [1:0] {
        OP_COPY = 2'h0,
        OP_DECODE = 2'h1,
        OP_ENCODE = 2'h2
    } op_t;

    typedef enum logic [3:0] {
        K_MODEM_IN = 4'h0,
        K_RX_DEC = 4'h1,
        K_JBIG_ENC = 4'h2,
        K_JBIG_DEC = 4'h3,
        K_PRINT = 4'h4,
        K_SCAN = 4'h5,
        K_MH_ENC = 4'h6,
        K_HOST_OUT = 4'h7,
        K_HOST_IN = 4'h8,
        K_HOST_DEC = 4'h9,
        K_TX_ENC = 4'ha,
        K_MODEM_OUT = 4'hb,
        K_HFMT_ENC = 4'hc,
        K_PRN_DEC = 4'hd
    } kind_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ISSUE = 4'b0010,
        ST_WAIT = 4'b0100,
        ST_NEXT = 4'b1000
    } fsm_t;

    typedef struct packed {
        buf_t src;
        region_t src_reg;
        buf_t dst;
        region_t dst_reg;
        op_t op;
        fmt_t fmt;
    } xfer_t;

    typedef struct packed {
        logic valid;
        logic [SCAN_WORD_W-1:0] data;
    } scan_word_t;

    localparam xfer_t XFER_RST = '{BUF_NONE, REG_EXT, BUF_NONE, REG_EXT,
                                   OP_COPY, FMT_RASTER};

endpackage : xfer_seq_pkg
